// file: core/bace_pkg.sv
// Constants and types shared by the burst area code encoder
package bace_pkg;
  // Sync and resync words
  localparam logic [7:0]  SYNC_FIXED   = 8'h46;   // 01000110, RZ channel bits
  localparam logic [3:0]  FSYNC_CODE   = 4'h0;
  localparam logic [3:0]  RSN_FIRST    = 4'h1;
  localparam logic [3:0]  RSN_LAST     = 4'hf;
  // Fixed field bytes
  localparam logic [7:0]  PRE_BYTE     = 8'h00;
  localparam logic [7:0]  POST_BYTE    = 8'h55;
  localparam logic [7:0]  PAD_BYTE     = 8'h00;
  // Size parameter range
  localparam logic [3:0]  N_MIN        = 4'h1;
  localparam logic [3:0]  N_MAX        = 4'hc;
  // Detection code: x^32 + x^31 + x^4 + 1 without the x^32 term
  localparam logic [31:0] EDC_POLY     = 32'h80000011;
  // Field x^8 + x^4 + x^3 + x^2 + 1 without the x^8 term
  localparam logic [7:0]  GF_POLY      = 8'h1d;
  // Parity generator (x+1)(x+a)(x+a^2)(x+a^3), monic
  localparam logic [7:0]  RS_G3        = 8'h0f;
  localparam logic [7:0]  RS_G2        = 8'h36;
  localparam logic [7:0]  RS_G1        = 8'h78;
  localparam logic [7:0]  RS_G0        = 8'h40;
  localparam logic [5:0]  RS_TOP_DEG   = 6'h34;   // 52, offset of check byte
  // Unit timing: 16 channel bits of two clocks each
  localparam logic [4:0]  UNIT_LAST    = 5'h1f;
  localparam logic [4:0]  READY_SLOT   = 5'h1e;
  localparam logic [1:0]  BYTE_LAST    = 2'h3;
  localparam logic [1:0]  ECC_GRP_LAST = 2'h3;

  // One unit is a sync word or a byte
  typedef enum logic [3:0] {
    U_IDLE    = 4'b0000,
    U_FSYNC   = 4'b0001,
    U_PRE     = 4'b0010,
    U_RS_INFO = 4'b0011,
    U_INFO    = 4'b0100,
    U_RS_EDC  = 4'b0101,
    U_EDC     = 4'b0110,
    U_RS_ECC  = 4'b0111,
    U_ECC     = 4'b1000,
    U_RS_POST = 4'b1001,
    U_POST    = 4'b1010,
    U_RS_END  = 4'b1011
  } bace_unit_t;
endpackage : bace_pkg

// file: core/bace_rs_lane.sv
// One Reed-Solomon parity interleave, Horner remainder over GF(256)
`timescale 1ns/1ps
module bace_rs_lane (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Control
  input  wire logic        clear,
  input  wire logic        step,
  input  wire logic [7:0]  din,
  // Remainder {x^3, x^2, x^1, x^0}
  output logic      [31:0] rem
);
  logic [31:0] rem_q;
  logic [31:0] rem_d;
  logic [7:0]  fb;

  // Multiply two field symbols
  function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] sh;
    acc = 8'h00;
    sh  = a;
    for (int k = 0; k < 8; k++) begin
      if (b[k]) acc = acc ^ sh;
      sh = sh[7] ? ({sh[6:0], 1'b0} ^ bace_pkg::GF_POLY) : {sh[6:0], 1'b0};
    end
    return acc;
  endfunction : gf_mul

  // Remainder times x plus input, reduced by the generator
  assign fb    = rem_q[31:24];
  assign rem_d = {rem_q[23:16] ^ gf_mul(fb, bace_pkg::RS_G3),
                  rem_q[15:8]  ^ gf_mul(fb, bace_pkg::RS_G2),
                  rem_q[7:0]   ^ gf_mul(fb, bace_pkg::RS_G1),
                  din          ^ gf_mul(fb, bace_pkg::RS_G0)};
  assign rem   = rem_q;

  // Remainder register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) rem_q <= 32'h0000_0000;
    else if (clear) rem_q <= 32'h0000_0000;
    else if (step) rem_q <= rem_d;
  end
endmodule : bace_rs_lane

// file: core/bace_encoder.sv
// Burst area code encoder: framing, check codes, phase and RZ modulation
`timescale 1ns/1ps
module bace_encoder (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Frame request
  input  wire logic       start,
  input  wire logic [3:0] size_n,
  // Information bytes
  input  wire logic [7:0] in_data,
  input  wire logic       in_valid,
  output logic            in_ready,
  // Stripe writer
  output logic            stripe,
  output logic            chan_bit,
  // Status
  output logic            busy,
  output logic            n_reject,
  output logic            underrun,
  output logic            frame_done
);
  bace_pkg::bace_unit_t unit_q, unit_d;
  logic [4:0]  cnt_q;
  logic [1:0]  b_q, b_d;
  logic [5:0]  g_q, g_d;
  logic [3:0]  n_q, rsn_q;
  logic [5:0]  zs_q;
  logic [15:0] ch_q;
  logic [7:0]  byte_q;
  logic [31:0] crc_q;
  logic [31:0] lane_rem [4];
  logic        in_ready_q, stripe_q, chan_bit_q, busy_q;
  logic        n_reject_q, underrun_q, frame_done_q;

  // Phase-encode a byte MSB first, optionally inverted
  function automatic logic [15:0] pe_byte(input logic [7:0] d,
                                          input logic inv);
    logic [15:0] r;
    r = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      r[2*k +: 2] = (d[k] ^ inv) ? 2'b10 : 2'b01;
    end
    return r;
  endfunction : pe_byte

  // Detection remainder update, one byte MSB first
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int k = 7; k >= 0; k--) begin
      r = (r[31] ^ d[k]) ? ({r[30:0], 1'b0} ^ bace_pkg::EDC_POLY)
                         : {r[30:0], 1'b0};
    end
    return r;
  endfunction : crc_byte

  // Decode of boundary, start and size
  wire        is_idle   = (unit_q == bace_pkg::U_IDLE);
  wire        n_ok      = (size_n >= bace_pkg::N_MIN) &&
                          (size_n <= bace_pkg::N_MAX);
  wire        go        = is_idle && start && n_ok;
  wire        boundary  = !is_idle && (cnt_q == bace_pkg::UNIT_LAST);
  wire        b_end     = (b_q == bace_pkg::BYTE_LAST);
  wire [5:0]  info_last = 6'({n_q, 2'b00} - 6'h2); // 4n-1 groups
  wire        load      = go || (boundary && unit_d != bace_pkg::U_IDLE);
  wire        feed_info = load && (unit_d == bace_pkg::U_INFO);
  wire        feed_edc  = load && (unit_d == bace_pkg::U_EDC);
  wire        take      = feed_info && in_valid;
  wire [7:0]  info_byte = take ? in_data : bace_pkg::PAD_BYTE;
  wire [7:0]  edc_byte  = crc_q[{~b_d, 3'b000} +: 8];
  wire [7:0]  ecc_byte  = lane_rem[g_d[1:0]][{~b_d, 3'b000} +: 8];
  wire [7:0]  feed_byte = feed_info ? info_byte : edc_byte;
  wire        zs_on     = (zs_q != 6'h00);
  wire        cur_bit   = ch_q[4'hf - cnt_q[4:1]];

  // Next unit and counters at a unit boundary
  always_comb begin
    unit_d = bace_pkg::U_IDLE;
    b_d    = 2'(b_q + 2'h1);
    g_d    = g_q;
    unique case (unit_q)
      bace_pkg::U_IDLE: begin
        unit_d = go ? bace_pkg::U_FSYNC : bace_pkg::U_IDLE;
      end
      bace_pkg::U_FSYNC: begin
        unit_d = bace_pkg::U_PRE;
        b_d    = 2'h0;
      end
      bace_pkg::U_PRE: begin
        unit_d = b_end ? bace_pkg::U_RS_INFO : bace_pkg::U_PRE;
        g_d    = 6'h00;
      end
      bace_pkg::U_RS_INFO, bace_pkg::U_RS_EDC, bace_pkg::U_RS_ECC,
      bace_pkg::U_RS_POST: begin
        b_d    = 2'h0;
        unit_d = bace_pkg::bace_unit_t'(unit_q + 4'h1);
      end
      bace_pkg::U_INFO: begin
        if (!b_end) unit_d = bace_pkg::U_INFO;
        else if (g_q == info_last) unit_d = bace_pkg::U_RS_EDC;
        else unit_d = bace_pkg::U_RS_INFO;
        if (b_end) g_d = 6'(g_q + 6'h1);
      end
      bace_pkg::U_EDC: begin
        unit_d = b_end ? bace_pkg::U_RS_ECC : bace_pkg::U_EDC;
        g_d    = 6'h00;
      end
      bace_pkg::U_ECC: begin
        if (!b_end) unit_d = bace_pkg::U_ECC;
        else if (g_q[1:0] == bace_pkg::ECC_GRP_LAST)
          unit_d = bace_pkg::U_RS_POST;
        else unit_d = bace_pkg::U_RS_ECC;
        if (b_end) g_d = 6'(g_q + 6'h1);
      end
      bace_pkg::U_POST: begin
        unit_d = b_end ? bace_pkg::U_RS_END : bace_pkg::U_POST;
      end
      bace_pkg::U_RS_END: begin
        unit_d = bace_pkg::U_IDLE;
      end
      default: begin
        unit_d = bace_pkg::U_IDLE;
      end
    endcase
  end

  // Byte and channel pattern of the next unit
  logic [7:0]  nbyte;
  logic [15:0] nch;
  logic [15:0] pe_inv;
  logic        nsync;
  always_comb begin
    nbyte = bace_pkg::PRE_BYTE;
    nsync = 1'b0;
    unique case (unit_d)
      bace_pkg::U_INFO: nbyte = info_byte;
      bace_pkg::U_EDC:  nbyte = edc_byte;
      bace_pkg::U_ECC:  nbyte = ecc_byte;
      bace_pkg::U_POST: nbyte = bace_pkg::POST_BYTE;
      bace_pkg::U_PRE:  nbyte = bace_pkg::PRE_BYTE;
      bace_pkg::U_FSYNC: begin
        nbyte = {bace_pkg::FSYNC_CODE, 4'h0};
        nsync = 1'b1;
      end
      default: begin
        nbyte = {rsn_q, 4'h0};
        nsync = 1'b1;
      end
    endcase
    // Inverted pattern held in a variable, a call result cannot be sliced
    pe_inv = pe_byte(nbyte, 1'b1);
    if (nsync)
      nch = {bace_pkg::SYNC_FIXED, pe_inv[15:8]};
    else if (unit_d == bace_pkg::U_INFO || unit_d == bace_pkg::U_EDC ||
             unit_d == bace_pkg::U_ECC)
      nch = pe_byte(nbyte, 1'b0);
    else
      nch = pe_inv;
  end

  // Parity lanes, one per interleave
  for (genvar j = 0; j < 4; j++) begin : g_lane
    bace_rs_lane u_lane (
      .clock (clock),
      .rstn  (rstn),
      .clear (go),
      .step  (zs_on || ((feed_info || feed_edc) && b_d == 2'(j))),
      .din   (zs_on ? 8'h00 : feed_byte),
      .rem   (lane_rem[j])
    );
  end

  // Sequencer state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      unit_q <= bace_pkg::U_IDLE;
      cnt_q  <= 5'h00;
      b_q    <= 2'h0;
      g_q    <= 6'h00;
      n_q    <= 4'h0;
    end else begin
      cnt_q <= is_idle ? 5'h00 : 5'(cnt_q + 5'h1);
      if (go) n_q <= size_n;
      if (go || boundary) begin
        unit_q <= unit_d;
        b_q    <= b_d;
        g_q    <= g_d;
      end
    end
  end

  // Channel pattern, current byte, resync number
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ch_q   <= 16'h0000;
      byte_q <= 8'h00;
      rsn_q  <= bace_pkg::RSN_FIRST;
    end else if (load) begin
      ch_q   <= nch;
      byte_q <= nbyte;
      if (go) rsn_q <= bace_pkg::RSN_FIRST;
      else if (nsync)
        rsn_q <= (rsn_q == bace_pkg::RSN_LAST) ? bace_pkg::RSN_FIRST
                                               : 4'(rsn_q + 4'h1);
    end
  end

  // Detection remainder and parity zero-shift count
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      crc_q <= 32'h0000_0000;
      zs_q  <= 6'h00;
    end else begin
      if (go) crc_q <= 32'h0000_0000;
      else if (feed_info) crc_q <= crc_byte(crc_q, info_byte);
      if (feed_edc && b_d == bace_pkg::BYTE_LAST)
        zs_q <= 6'(bace_pkg::RS_TOP_DEG - {n_q, 2'b00});
      else if (zs_on) zs_q <= 6'(zs_q - 6'h1);
    end
  end

  // Registered outputs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      in_ready_q   <= 1'b0;
      stripe_q     <= 1'b0;
      chan_bit_q   <= 1'b0;
      busy_q       <= 1'b0;
      n_reject_q   <= 1'b0;
      underrun_q   <= 1'b0;
      frame_done_q <= 1'b0;
    end else begin
      in_ready_q   <= !is_idle && cnt_q == bace_pkg::READY_SLOT &&
                      unit_d == bace_pkg::U_INFO;
      stripe_q     <= !is_idle && cur_bit && !cnt_q[0];
      chan_bit_q   <= !is_idle && cur_bit;
      busy_q       <= !is_idle;
      n_reject_q   <= is_idle && start && !n_ok;
      underrun_q   <= feed_info && !in_valid;
      frame_done_q <= boundary && unit_q == bace_pkg::U_RS_END;
    end
  end

  assign in_ready   = in_ready_q;
  assign stripe     = stripe_q;
  assign chan_bit   = chan_bit_q;
  assign busy       = busy_q;
  assign n_reject   = n_reject_q;
  assign underrun   = underrun_q;
  assign frame_done = frame_done_q;

  // Checks
  wire data_unit = unit_q == bace_pkg::U_INFO || unit_q == bace_pkg::U_EDC ||
                   unit_q == bace_pkg::U_ECC;
  wire fix_unit  = unit_q == bace_pkg::U_PRE || unit_q == bace_pkg::U_POST;
  wire dbit      = byte_q[3'h7 - cnt_q[4:2]];

  a_rz_pulse: assert property (@(posedge clock) disable iff (!rstn)
    stripe |=> !stripe) else $error("stripe longer than half bit");
  a_reject_n: assert property (@(posedge clock) disable iff (!rstn)
    (is_idle && start && !n_ok) |=> (n_reject && is_idle))
    else $error("bad size not rejected");
  a_norm_map: assert property (@(posedge clock) disable iff (!rstn)
    (data_unit && cnt_q[1:0] == 2'b00) |-> (cur_bit == dbit) ##2
    (cur_bit == !$past(dbit, 2))) else $error("normal mapping wrong");
  a_inv_map: assert property (@(posedge clock) disable iff (!rstn)
    (fix_unit && cnt_q[1:0] == 2'b00) |-> (cur_bit == !dbit))
    else $error("inverted mapping wrong");
  a_pre_after: assert property (@(posedge clock) disable iff (!rstn)
    (unit_q == bace_pkg::U_FSYNC && boundary) |=>
    (unit_q == bace_pkg::U_PRE && byte_q == bace_pkg::PRE_BYTE))
    else $error("lead field missing");
  a_no_gap: assert property (@(posedge clock) disable iff (!rstn)
    (boundary && unit_q != bace_pkg::U_RS_END) |=>
    (!is_idle && cnt_q == 5'h00)) else $error("gap in stream");
  a_sync_fixed: assert property (@(posedge clock) disable iff (!rstn)
    (!is_idle && !data_unit && !fix_unit) |->
    (ch_q[15:8] == bace_pkg::SYNC_FIXED)) else $error("bad sync word");
  a_post_val: assert property (@(posedge clock) disable iff (!rstn)
    (unit_q == bace_pkg::U_POST && boundary && b_end) |=>
    (unit_q == bace_pkg::U_RS_END)) else $error("tail resync missing");
  a_parity_ready: assert property (@(posedge clock) disable iff (!rstn)
    (unit_q == bace_pkg::U_ECC) |-> !zs_on)
    else $error("parity read before done");
  c_frame: cover property (@(posedge clock) disable iff (!rstn) frame_done);
  c_reject: cover property (@(posedge clock) disable iff (!rstn) n_reject);
  c_underrun: cover property (@(posedge clock) disable iff (!rstn) underrun);
endmodule : bace_encoder

// file: sim/bace_stripe_rec.sv
// Stripe writer model: collects channel bits and checks RZ pulses
`timescale 1ns/1ps
module bace_stripe_rec (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Stream from the encoder
  input  wire logic stripe,
  input  wire logic chan_bit,
  input  wire logic busy,
  // Count of pulse violations
  output int        rz_err
);
  // Sector where lead-in recording resumes once the code is written
  localparam logic [23:0] LEAD_IN_SECTOR = 24'h02d5b0;
  logic        bits[$];
  logic        phase_q;
  logic        busy_q;
  logic [23:0] lead_in_q;

  // One channel bit per two clocks, pulse only in the first half
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase_q = 1'b0;
      busy_q = 1'b0;
      rz_err = 0;
      lead_in_q = 24'h000000;
    end else begin
      if (busy && !busy_q) bits.delete();
      if (!busy && busy_q) lead_in_q = LEAD_IN_SECTOR;
      if (busy && !phase_q) bits.push_back(chan_bit);
      if (stripe !== (busy && !phase_q && chan_bit)) rz_err++;
      phase_q = busy ? !phase_q : 1'b0;
      busy_q = busy;
    end
  end
endmodule : bace_stripe_rec

// file: sim/tb_top.sv
// Self-checking bench for the burst area code encoder
`timescale 1ns/1ps
module tb_top;
  logic       clock, rstn, start, in_valid, full_valid;
  logic [3:0] size_n;
  logic [7:0] in_data;
  logic       in_ready, stripe, chan_bit, busy;
  logic       n_reject, underrun, frame_done;
  int         num_errors, checked, exp_under, seen_under, seen_rej;
  int         rz_err, fm;
  logic [7:0] info[$];
  logic [7:0] cp[16];
  logic       expq[$];

  bace_encoder dut (.clock(clock), .rstn(rstn), .start(start),
    .size_n(size_n), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready), .stripe(stripe), .chan_bit(chan_bit),
    .busy(busy), .n_reject(n_reject), .underrun(underrun),
    .frame_done(frame_done));
  bace_stripe_rec rec (.clock(clock), .rstn(rstn), .stripe(stripe),
    .chan_bit(chan_bit), .busy(busy), .rz_err(rz_err));

  // Clock and watchdog
  always #2.5 clock = ~clock;
  initial begin
    #300000;
    num_errors++;
    finish_test();
  end

  // Host side: random bytes, records what each offer takes
  always @(posedge clock) begin
    if (in_ready) begin
      info.push_back(in_valid ? in_data : 8'h00);
      if (!in_valid) exp_under++;
    end
    if (underrun) seen_under++;
    if (n_reject) seen_rej++;
    in_data <= 8'($urandom);
    in_valid <= full_valid || ($urandom % 4 != 0);
  end

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ a;
      a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1d : 8'h00);
    end
    return p;
  endfunction : gmul

  function automatic void put_byte(input logic [7:0] b, input logic inv);
    for (int i = 7; i >= 0; i--) begin
      expq.push_back(b[i] ^ inv);
      expq.push_back(!b[i] ^ inv);
    end
  endfunction : put_byte

  function automatic void put_sync(input logic [3:0] code);
    logic [7:0] f;
    f = 8'h46;
    for (int i = 7; i >= 0; i--) expq.push_back(f[i]);
    for (int i = 3; i >= 0; i--) begin
      expq.push_back(!code[i]);
      expq.push_back(code[i]);
    end
  endfunction : put_sync

  // Expected channel bits of a whole frame
  function automatic void build(input int n);
    logic [31:0] crc;
    logic [7:0]  g[5];
    logic [7:0]  d[4];
    logic [7:0]  r[4];
    logic [7:0]  a, fb, s;
    int          rsn;
    expq.delete();
    crc = 32'h0;
    foreach (info[i]) for (int t = 7; t >= 0; t--) begin
      fb[0] = crc[31] ^ info[i][t];
      crc = {crc[30:0], 1'b0} ^ (fb[0] ? 32'h80000011 : 32'h0);
    end
    for (int k = 0; k < 4; k++) d[k] = crc[31-8*k -: 8];
    g = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    a = 8'h01;
    for (int k = 0; k < 4; k++) begin
      for (int i = 4; i > 0; i--) g[i] = g[i-1] ^ gmul(a, g[i]);
      g[0] = gmul(a, g[0]);
      a = gmul(a, 8'h02);
    end
    for (int j = 0; j < 4; j++) begin
      r = '{default: 8'h00};
      for (int i = 0; i < 48; i++) begin
        s = (i < 4*n-1) ? info[j+4*i] : (i == 4*n-1) ? d[j] : 8'h00;
        fb = s ^ r[3];
        for (int k = 3; k > 0; k--) r[k] = r[k-1] ^ gmul(fb, g[k]);
        r[0] = gmul(fb, g[0]);
      end
      for (int k = 0; k < 4; k++) cp[4*j+k] = r[3-k];
    end
    put_sync(4'h0);
    for (int k = 0; k < 4; k++) put_byte(8'h00, 1'b1);
    rsn = 1;
    for (int u = 0; u < 4*n+5; u++) begin
      put_sync(rsn[3:0]);
      rsn = (rsn == 15) ? 1 : rsn + 1;
      for (int k = 0; k < 4; k++) begin
        if (u < 4*n-1) put_byte(info[4*u+k], 1'b0);
        else if (u == 4*n-1) put_byte(d[k], 1'b0);
        else if (u < 4*n+4) put_byte(cp[4*(u-4*n)+k], 1'b0);
        else put_byte(8'h55, 1'b1);
      end
    end
    put_sync(rsn[3:0]);
  endfunction : build

  // One frame with a second start offered while busy
  task automatic run_frame(input int n);
    int k, rej0;
    info.delete();
    exp_under = 0;
    seen_under = 0;
    start <= 1'b1;
    size_n <= 4'(n);
    @(posedge clock);
    start <= 1'b0;
    size_n <= 4'h0;
    @(posedge clock);
    #1 chk("busy_rise", 1, busy);
    repeat (100) @(posedge clock);
    rej0 = seen_rej;
    start <= 1'b1;
    size_n <= 4'(n);
    @(posedge clock);
    start <= 1'b0;
    k = 0;
    while (frame_done !== 1'b1 && k < 10000) begin
      @(posedge clock);
      k++;
    end
    repeat (3) @(posedge clock);
    chk("frame_done_seen", 1, k < 10000);
    chk("busy_end", 0, busy);
    chk("lead_in_start", 32'h0002d5b0, {8'h00, rec.lead_in_q});
    chk("start_refused", rej0, seen_rej);
    chk("info_count", 16*n-4, info.size());
    chk("underruns", exp_under, seen_under);
    chk("rz_errors", 0, rz_err);
    build(n);
    fm = -1;
    foreach (expq[i]) if (fm < 0 && rec.bits[i] !== expq[i]) fm = i;
    chk("stream_len_ok", 1, rec.bits.size() >= expq.size());
    chk("first_bad_bit", 32'hffffffff, fm);
  endtask : run_frame

  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    int bad[4];
    void'($urandom(32'h6165));
    clock = 1'b0;
    rstn = 1'b0;
    start = 1'b0;
    size_n = 4'h0;
    in_data = 8'h00;
    in_valid = 1'b0;
    full_valid = 1'b1;
    num_errors = 0;
    checked = 0;
    seen_rej = 0;
    bad = '{0, 13, 14, 15};
    repeat (6) @(posedge clock);
    chk("reset_outs", 0, {in_ready, stripe, chan_bit, busy, n_reject,
                          underrun, frame_done});
    rstn <= 1'b1;
    @(posedge clock);
    foreach (bad[i]) begin
      start <= 1'b1;
      size_n <= 4'(bad[i]);
      @(posedge clock);
      start <= 1'b0;
      #1 chk("n_reject", 1, n_reject);
      chk("busy_after_bad_n", 0, busy);
      @(posedge clock);
    end
    run_frame(1);
    full_valid = 1'b0;
    run_frame(12);
    run_frame(1 + $urandom % 12);
    run_frame(1 + $urandom % 12);
    finish_test();
  end
endmodule : tb_top
